// ===== rtl/deadband_delay.sv
// one dead-band delay lane: delays rising edges only
`timescale 1ns/1ps
module deadband_delay (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic hold,
    input wire logic [6:0] count,
    input wire logic tick,
    input wire logic raw,
    // result
    output logic delayed
);
    import hb_pwm_pkg::*;

    logic [6:0] remaining;
    logic raw_q;
    wire rise = raw && !raw_q;
    wire expired = (remaining == 7'h00);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remaining <= 7'h00;
            raw_q <= 1'b0;
            delayed <= 1'b0;
        end else if (!hold) begin
            raw_q <= raw;
            if (!raw) begin
                delayed <= 1'b0; // falls at once
            end else if (rise) begin
                remaining <= count; // restart at each scheduled rise
                delayed <= (count == 7'h00);
            end else if (!expired && tick) begin
                remaining <= remaining - 7'h01;
            end else if (expired) begin
                // one clock after expiry, so a rise lags by whole units plus one clock; a fall does not lag
                delayed <= 1'b1;
            end
        end
    end

    a_fall_immediate: assert property (@(posedge pclk) disable iff (!presetn)
        (!hold && !raw) |=> !delayed) else $error("delayed output did not fall");
endmodule : deadband_delay

// ===== rtl/hb_pwm_pkg.sv
// constants for the half-bridge pwm output stage with shutdown and dead-band
package hb_pwm_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_SHUTDOWN_CONFIG = 8'h00;
    localparam logic [7:0] OFS_DEADBAND_RESTART = 8'h04;
    localparam logic [7:0] OFS_PWM_CONTROL = 8'h08;
    localparam logic [7:0] OFS_PERIOD_LIMIT = 8'h0C;
    localparam logic [7:0] OFS_DUTY = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int EVENT_FLAG_BIT = 7;
    localparam int SOURCE_LSB = 4;
    localparam int PIN_A_STATE_LSB = 2;
    localparam int PIN_B_STATE_LSB = 0;
    localparam int RESTART_BIT = 7;
    localparam int CTL_ENABLE_BIT = 0;
    localparam int CTL_MODE_LSB = 1;
    localparam int CTL_POL_A_BIT = 3;
    localparam int CTL_POL_B_BIT = 4;
    localparam int CTL_DRV_A_BIT = 5;
    localparam int CTL_DRV_B_BIT = 6;
    localparam int CTL_SYNC_BIT = 7;
    localparam int CTL_SLEEP_BIT = 8;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] SHUTDOWN_CONFIG_RESET = 8'h00;
    localparam logic [7:0] DEADBAND_RESTART_RESET = 8'h00;
    localparam logic [8:0] PWM_CONTROL_RESET = 9'h000;
    localparam logic [7:0] PERIOD_LIMIT_RESET = 8'hFF;
    localparam logic [7:0] DUTY_RESET = 8'h00;
    // ------------------------------------------------------------
    // timing: one instruction cycle is four oscillator periods
    // ------------------------------------------------------------
    localparam int INSTR_CYCLE_CLOCKS = 4;
    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_HALF_BRIDGE = 2'h2;
    localparam logic [1:0] SAFE_LOW = 2'h0;
    localparam logic [1:0] SAFE_HIGH = 2'h1;
    typedef enum logic [1:0] {
        RUN_ACTIVE = 2'b00,
        RUN_SHUTDOWN = 2'b01,
        RUN_WAIT_PERIOD = 2'b10
    } run_state_t;
endpackage : hb_pwm_pkg

// ===== rtl/hb_pwm_shutdown.sv
// half-bridge pwm output stage with auto-shutdown, restart and dead-band
// ------------------------------------------------------------
// ------------------------------------------------------------
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module hb_pwm_shutdown (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // shutdown sources and the comparator sync tick
    input wire logic int_pin,
    input wire logic comparator_out,
    input wire logic aux_timer_tick,
    // pwm pins
    output logic pwm_out_a,
    output logic pwm_out_a_oe,
    output logic pwm_out_b,
    output logic pwm_out_b_oe,
    // status
    output logic period_timer_flag
);
    import hb_pwm_pkg::*;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] shutdown_config_register;
    logic [7:0] deadband_restart_control;
    logic [8:0] pwm_control_word;
    logic [7:0] period_limit;
    logic [7:0] duty;
    logic [7:0] period_timer;
    logic [1:0] prescale;
    logic [1:0] periods_seen;
    logic shutdown_event_flag;
    run_state_t run_state;
    logic int_s1, int_s2, cmp_s1, cmp_s2, cmp_q, tick_s1, tick_s2;
    logic cmp_pending;

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    wire [2:0] shutdown_source_select = shutdown_config_register[SOURCE_LSB +: 3];
    wire [1:0] pin_a_shutdown_state = shutdown_config_register[PIN_A_STATE_LSB +: 2];
    wire [1:0] pin_b_shutdown_state = shutdown_config_register[PIN_B_STATE_LSB +: 2];
    wire auto_restart_enable = deadband_restart_control[RESTART_BIT];
    wire [6:0] deadband_count = deadband_restart_control[6:0];
    wire pwm_enable = pwm_control_word[CTL_ENABLE_BIT];
    wire [1:0] output_mode_select = pwm_control_word[CTL_MODE_LSB +: 2];
    wire [1:0] output_polarity_select = {pwm_control_word[CTL_POL_B_BIT],
                                         pwm_control_word[CTL_POL_A_BIT]};
    wire drive_a = pwm_control_word[CTL_DRV_A_BIT];
    wire drive_b = pwm_control_word[CTL_DRV_B_BIT];
    wire comparator_sync_enable = pwm_control_word[CTL_SYNC_BIT];
    wire sleep = pwm_control_word[CTL_SLEEP_BIT];
    wire half_bridge = (output_mode_select == MODE_HALF_BRIDGE);

    // ------------------------------------------------------------
    // shutdown condition
    // ------------------------------------------------------------
    wire use_cmp = shutdown_source_select[0];
    wire use_pin = shutdown_source_select[2];
    wire cmp_change = (cmp_s2 != cmp_q);
    wire cmp_event = comparator_sync_enable ? (cmp_pending && tick_s2) : cmp_change;
    wire hw_condition = (use_pin && !int_s2) || (use_cmp && cmp_event);
    // raw pin level also acts without a clock for the forced outputs
    wire async_pin_off = use_pin && !int_pin;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire access = psel && penable;
    wire wr = access && pwrite;
    wire addr_ok = (paddr == OFS_SHUTDOWN_CONFIG) || (paddr == OFS_DEADBAND_RESTART)
                || (paddr == OFS_PWM_CONTROL) || (paddr == OFS_PERIOD_LIMIT)
                || (paddr == OFS_DUTY) || (paddr == OFS_STATUS);
    wire wr_cfg = wr && (paddr == OFS_SHUTDOWN_CONFIG);
    wire sw_flag_set = wr_cfg && pwdata[EVENT_FLAG_BIT] && !hw_condition;
    wire sw_flag_clear = wr_cfg && !pwdata[EVENT_FLAG_BIT] && !hw_condition;
    wire clear_ok = !auto_restart_enable && sw_flag_clear;
    wire auto_clear = auto_restart_enable && !hw_condition && shutdown_event_flag;

    logic [31:0] next_prdata;
    always_comb begin
        next_prdata = 32'h0000_0000;
        case (paddr)
            OFS_SHUTDOWN_CONFIG: next_prdata = {24'h000000, shutdown_event_flag,
                                                shutdown_config_register[6:0]};
            OFS_DEADBAND_RESTART: next_prdata = {24'h000000, deadband_restart_control};
            OFS_PWM_CONTROL: next_prdata = {23'h000000, pwm_control_word};
            OFS_PERIOD_LIMIT: next_prdata = {24'h000000, period_limit};
            OFS_DUTY: next_prdata = {24'h000000, duty};
            OFS_STATUS: next_prdata = {22'h000000, run_state, period_timer};
            default: next_prdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            prdata <= (psel && !penable && !pwrite) ? next_prdata : 32'h0000_0000;
        end
    end

    // writes take effect at the access edge where pready is high
    wire wr_done = wr && pready;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shutdown_config_register <= SHUTDOWN_CONFIG_RESET;
            deadband_restart_control <= DEADBAND_RESTART_RESET;
            pwm_control_word <= PWM_CONTROL_RESET;
            period_limit <= PERIOD_LIMIT_RESET;
            duty <= DUTY_RESET;
        end else if (wr_done) begin
            case (paddr)
                OFS_SHUTDOWN_CONFIG: shutdown_config_register <= pwdata[7:0];
                OFS_DEADBAND_RESTART: deadband_restart_control <= pwdata[7:0];
                OFS_PWM_CONTROL: pwm_control_word <= pwdata[8:0];
                OFS_PERIOD_LIMIT: period_limit <= pwdata[7:0];
                OFS_DUTY: duty <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // synchronisers and shutdown flag
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_s1 <= 1'b1;
            int_s2 <= 1'b1;
            cmp_s1 <= 1'b0;
            cmp_s2 <= 1'b0;
            cmp_q <= 1'b0;
            tick_s1 <= 1'b0;
            tick_s2 <= 1'b0;
            cmp_pending <= 1'b0;
        end else begin
            int_s1 <= int_pin;
            int_s2 <= int_s1;
            cmp_s1 <= comparator_out;
            cmp_s2 <= cmp_s1;
            cmp_q <= cmp_s2;
            tick_s1 <= aux_timer_tick;
            tick_s2 <= tick_s1;
            if (cmp_change && comparator_sync_enable) begin
                cmp_pending <= 1'b1;
            end else if (tick_s2 || !comparator_sync_enable) begin
                cmp_pending <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shutdown_event_flag <= 1'b0;
        end else if (hw_condition || (wr_done && sw_flag_set)) begin
            shutdown_event_flag <= 1'b1; // set beats clear
        end else if ((wr_done && clear_ok) || auto_clear) begin
            shutdown_event_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // period timer; sleep freezes the registers below while pwm is enabled
    // ------------------------------------------------------------
    wire tcy_tick = (prescale == 2'(INSTR_CYCLE_CLOCKS - 1));
    wire period_end = tcy_tick && (period_timer == period_limit);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale <= 2'h0;
            period_timer <= 8'h00;
            periods_seen <= 2'h0;
            period_timer_flag <= 1'b0;
        end else if (!sleep && pwm_enable) begin
            prescale <= prescale + 2'h1;
            if (tcy_tick) begin
                period_timer <= period_end ? 8'h00 : period_timer + 8'h01;
            end
            if (period_end && periods_seen != 2'h2) begin
                periods_seen <= periods_seen + 2'h1;
            end
            // first end marks the second period start
            period_timer_flag <= period_end || period_timer_flag;
        end else if (!pwm_enable) begin
            prescale <= 2'h0;
            period_timer <= 8'h00;
            periods_seen <= 2'h0;
            period_timer_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // run state: shutdown and wait for next period
    // ------------------------------------------------------------
    run_state_t next_run_state;
    always_comb begin
        case (run_state)
            RUN_ACTIVE: next_run_state = shutdown_event_flag ? RUN_SHUTDOWN : RUN_ACTIVE;
            RUN_SHUTDOWN: next_run_state = shutdown_event_flag ? RUN_SHUTDOWN
                                                               : RUN_WAIT_PERIOD;
            RUN_WAIT_PERIOD: next_run_state = shutdown_event_flag ? RUN_SHUTDOWN
                                            : (period_end ? RUN_ACTIVE : RUN_WAIT_PERIOD);
            default: next_run_state = RUN_SHUTDOWN;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_state <= RUN_WAIT_PERIOD;
        end else if (!sleep) begin
            run_state <= next_run_state; // resume only at period start
        end
    end

    // ------------------------------------------------------------
    // waveform, dead-band and pins
    // ------------------------------------------------------------
    wire raw_pwm = (period_timer < duty) && (run_state == RUN_ACTIVE);
    wire raw_a = raw_pwm;
    wire raw_b = half_bridge ? (!raw_pwm && run_state == RUN_ACTIVE) : raw_pwm;
    wire use_deadband = half_bridge;
    logic dly_a, dly_b;

    // long dead-band simply never expires within the period
    deadband_delay u_delay_a (
        .pclk(pclk),
        .presetn(presetn),
        .hold(sleep),
        .count(use_deadband ? deadband_count : 7'h00),
        .tick(tcy_tick),
        .raw(raw_a),
        .delayed(dly_a)
    );
    deadband_delay u_delay_b (
        .pclk(pclk),
        .presetn(presetn),
        .hold(sleep),
        .count(use_deadband ? deadband_count : 7'h00),
        .tick(tcy_tick),
        .raw(raw_b),
        .delayed(dly_b)
    );

    logic act_a, act_b, oe_a, oe_b;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_a <= 1'b0;
            act_b <= 1'b0;
            oe_a <= 1'b0; // pins released after reset
            oe_b <= 1'b0;
        end else if (!sleep) begin
            act_a <= dly_a ^ output_polarity_select[0];
            act_b <= dly_b ^ output_polarity_select[1];
            oe_a <= drive_a && pwm_enable;
            oe_b <= drive_b && pwm_enable;
        end
    end

    // forced path bypasses the clock so a pin fault acts at once
    wire forced = shutdown_event_flag || async_pin_off;
    always_comb begin
        pwm_out_a = act_a;
        pwm_out_a_oe = oe_a;
        pwm_out_b = act_b;
        pwm_out_b_oe = oe_b;
        if (forced && oe_a) begin
            pwm_out_a = (pin_a_shutdown_state == SAFE_HIGH);
            pwm_out_a_oe = !pin_a_shutdown_state[1];
        end
        if (forced && oe_b) begin
            pwm_out_b = (pin_b_shutdown_state == SAFE_HIGH);
            pwm_out_b_oe = !pin_b_shutdown_state[1];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_hw_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
        hw_condition |=> shutdown_event_flag) else $error("flag not set");
    a_set_beats_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (hw_condition && wr_done && wr_cfg) |=> shutdown_event_flag)
        else $error("clear won over set");
    a_write_ignored: assert property (@(posedge pclk) disable iff (!presetn)
        (shutdown_event_flag && hw_condition) |=> shutdown_event_flag)
        else $error("flag dropped under condition");
    a_auto_restart: assert property (@(posedge pclk) disable iff (!presetn)
        (auto_clear && !(wr_done && sw_flag_set)) |=> !shutdown_event_flag)
        else $error("auto restart missed");
    a_shutdown_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
        (shutdown_event_flag && oe_a && pin_a_shutdown_state == SAFE_LOW)
        |-> (pwm_out_a_oe && !pwm_out_a)) else $error("pin a not safe");
    a_shutdown_pin_b: assert property (@(posedge pclk) disable iff (!presetn)
        (shutdown_event_flag && oe_b && pin_b_shutdown_state[1]) |-> !pwm_out_b_oe)
        else $error("pin b not released");
    a_resume_period: assert property (@(posedge pclk) disable iff (!presetn)
        (run_state == RUN_WAIT_PERIOD && !period_end && !sleep) |=> run_state != RUN_ACTIVE)
        else $error("resumed mid period");
    a_sleep_freeze: assert property (@(posedge pclk) disable iff (!presetn)
        (sleep && $past(sleep)) |-> $stable(period_timer)) else $error("timer ran");
    c_shutdown: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(shutdown_event_flag));
    c_restart: cover property (@(posedge pclk) disable iff (!presetn)
        run_state == RUN_WAIT_PERIOD ##1 run_state == RUN_ACTIVE);
    c_half_bridge: cover property (@(posedge pclk) disable iff (!presetn)
        half_bridge && $rose(dly_b));
endmodule : hb_pwm_shutdown

// ===== verification/hb_switch_model.sv
// half-bridge switch pair model: gate nets with pull-downs
`timescale 1ns/1ps
module hb_switch_model (
    // pins from the pwm stage
    input wire logic pin_a,
    input wire logic pin_a_oe,
    input wire logic pin_b,
    input wire logic pin_b_oe,
    // resolved gate levels
    output logic gate_high,
    output logic gate_low,
    output logic shoot_through
);
    // ------------------------------------------------------------
    // gate nets
    // ------------------------------------------------------------
    // pull-downs hold both switches off while the pins float
    assign gate_high = pin_a_oe ? pin_a : 1'b0;
    assign gate_low = pin_b_oe ? pin_b : 1'b0;
    // both switches on would short the bridge supply
    assign shoot_through = gate_high & gate_low;
endmodule : hb_switch_model

// ===== verification/tb.sv
// self-checking bench for the half-bridge pwm stage
`timescale 1ns/1ps
module tb;
    import hb_pwm_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic int_pin = 1'b1;
    logic comparator_out = 1'b0;
    logic aux_timer_tick = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, pwm_out_a, pwm_out_a_oe, pwm_out_b, pwm_out_b_oe;
    logic period_timer_flag, gate_high, gate_low, shoot_through, err;
    logic [31:0] rd;
    logic [31:0] held;
    int err_total = 0;
    int checked = 0;
    int n;

    always #50 pclk = ~pclk;

    hb_pwm_shutdown i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .int_pin(int_pin), .comparator_out(comparator_out), .aux_timer_tick(aux_timer_tick),
        .pwm_out_a(pwm_out_a), .pwm_out_a_oe(pwm_out_a_oe), .pwm_out_b(pwm_out_b),
        .pwm_out_b_oe(pwm_out_b_oe), .period_timer_flag(period_timer_flag));
    hb_switch_model i_switches (
        .pin_a(pwm_out_a), .pin_a_oe(pwm_out_a_oe), .pin_b(pwm_out_b), .pin_b_oe(pwm_out_b_oe),
        .gate_high(gate_high), .gate_low(gate_low), .shoot_through(shoot_through));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic complete_run;
        if (err_total == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic cycles(input int k);
        repeat (k) @(posedge pclk);
    endtask : cycles

    task automatic apb(input logic is_wr, input logic [7:0] addr, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= is_wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
        apb(1'b1, addr, wd);
    endtask : wr

    task automatic rd_chk(input string what, input logic [7:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        chk(what, exp, rd);
    endtask : rd_chk

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    always @(posedge pclk) begin
        if (shoot_through === 1'b1) begin
            err_total++;
            $display("Error shoot_through expected 0 seen 1");
        end
    end

    initial begin
        #1_000_000;
        err_total++;
        complete_run();
    end

    initial begin
        cycles(10);
        presetn <= 1'b1;
        #1;
        chk("oe_a", 32'h0, pwm_out_a_oe);
        chk("oe_b", 32'h0, pwm_out_b_oe);
        rd_chk("cfg_reset", OFS_SHUTDOWN_CONFIG, 32'h0);
        apb(1'b0, 8'hFC, 32'h0);
        chk("slverr", 32'h1, err);
        wr(OFS_PERIOD_LIMIT, 32'h07);
        wr(OFS_DUTY, 32'h04);
        wr(OFS_DEADBAND_RESTART, 32'h02);
        // polarity fixed active high before any driver is on
        wr(OFS_PWM_CONTROL, 32'h005);
        chk("period_flag_early", 32'h0, period_timer_flag);
        for (n = 0; n < 200 && period_timer_flag !== 1'b1; n++) cycles(1);
        chk("period_flag", 32'h1, n >= 4 && n < 200);
        wr(OFS_PWM_CONTROL, 32'h065);
        for (n = 0; n < 100 && pwm_out_a !== 1'b1; n++) cycles(1);
        for (n = 0; n < 100 && pwm_out_a !== 1'b0; n++) cycles(1);
        for (n = 0; n < 100 && pwm_out_b !== 1'b1; n++) cycles(1);
        chk("deadband_gap", 32'h1, n >= 8 && n <= 12);
        wr(OFS_SHUTDOWN_CONFIG, 32'h84);
        cycles(1);
        chk("pin_a", 32'h1, pwm_out_a & pwm_out_a_oe & gate_high);
        chk("pin_b", 32'h1, !pwm_out_b & pwm_out_b_oe);
        rd_chk("fw_flag", OFS_SHUTDOWN_CONFIG, 32'h84);
        wr(OFS_SHUTDOWN_CONFIG, 32'h4B);
        @(posedge pclk);
        int_pin <= 1'b0;
        // no edge allowed here: the pins must float at once
        #1;
        chk("async_oe", 32'h0, pwm_out_a_oe | pwm_out_b_oe);
        wr(OFS_SHUTDOWN_CONFIG, 32'h4B);
        rd_chk("clear_blocked", OFS_SHUTDOWN_CONFIG, 32'hCB);
        int_pin <= 1'b1;
        cycles(3);
        wr(OFS_SHUTDOWN_CONFIG, 32'h4B);
        rd_chk("sw_clear", OFS_SHUTDOWN_CONFIG, 32'h4B);
        wr(OFS_DEADBAND_RESTART, 32'h82);
        rd_chk("restart_reg", OFS_DEADBAND_RESTART, 32'h82);
        int_pin <= 1'b0;
        cycles(4);
        rd_chk("restart_hold", OFS_SHUTDOWN_CONFIG, 32'hCB);
        int_pin <= 1'b1;
        cycles(4);
        rd_chk("restart_clear", OFS_SHUTDOWN_CONFIG, 32'h4B);
        wr(OFS_DEADBAND_RESTART, 32'h02);
        for (int s = 0; s < 8; s++) begin
            wr(OFS_SHUTDOWN_CONFIG, {24'h0, 1'b0, s[2:0], 4'h4});
            int_pin <= 1'b0;
            cycles(3);
            int_pin <= 1'b1;
            rd_chk("src_pin", OFS_SHUTDOWN_CONFIG, {24'h0, s[2], s[2:0], 4'h4});
            cycles(3);
            wr(OFS_SHUTDOWN_CONFIG, {24'h0, 1'b0, s[2:0], 4'h4});
            comparator_out <= ~comparator_out;
            cycles(4);
            rd_chk("src_cmp", OFS_SHUTDOWN_CONFIG, {24'h0, s[0], s[2:0], 4'h4});
            wr(OFS_SHUTDOWN_CONFIG, {24'h0, 1'b0, s[2:0], 4'h4});
        end
        // comparator shutdown held back until the aux timer ticks
        wr(OFS_PWM_CONTROL, 32'h0E5);
        wr(OFS_SHUTDOWN_CONFIG, 32'h14);
        comparator_out <= ~comparator_out;
        cycles(6);
        rd_chk("sync_wait", OFS_SHUTDOWN_CONFIG, 32'h14);
        aux_timer_tick <= 1'b1;
        cycles(1);
        aux_timer_tick <= 1'b0;
        cycles(4);
        rd_chk("sync_fire", OFS_SHUTDOWN_CONFIG, 32'h94);
        wr(OFS_SHUTDOWN_CONFIG, 32'h00);
        wr(OFS_PWM_CONTROL, 32'h165);
        apb(1'b0, OFS_STATUS, 32'h0);
        held = rd;
        cycles(20);
        rd_chk("sleep_freeze", OFS_STATUS, held);
        // drivers off while pin a turns active low
        wr(OFS_PWM_CONTROL, 32'h00D);
        cycles(2);
        for (n = 0; n < 100 && pwm_out_b !== 1'b1; n++) cycles(1);
        chk("pol_a", 32'h1, pwm_out_a);
        complete_run();
    end
endmodule : tb
